// ---- core/scs_defines.svh ----
// shared constants for the smart card supply supervisor host controller
// assumes a 250 MHz clock; all times but the removal limit converted to cycles here
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

`define SCS_CLK_PERIOD_PS 4000
// 40 ms presence debounce as seen at card_present_n
`define SCS_DEBOUNCE_MS 40
// 50 us worst case for card_present_n to rise after removal
`define SCS_REMOVAL_US 50
// ready wait limit chosen by the host: 10 ms
`define SCS_READY_WAIT_MS 10
// quiet gap after power release before a new request: 1 ms
`define SCS_IDLE_GAP_US 1000
// ps per ms held in 64 bits so the product cannot wrap
`define SCS_PS_PER_MS 64'h0000_0000_3b9a_ca00
`define SCS_DEBOUNCE_CYC ((`SCS_DEBOUNCE_MS * `SCS_PS_PER_MS) / `SCS_CLK_PERIOD_PS)
`define SCS_READY_WAIT_CYC ((`SCS_READY_WAIT_MS * `SCS_PS_PER_MS) / `SCS_CLK_PERIOD_PS)
`define SCS_IDLE_GAP_CYC ((`SCS_IDLE_GAP_US * 1000000) / `SCS_CLK_PERIOD_PS)
`define SCS_CNT_W 24

// software register offsets (byte addresses)
`define SCS_REG_CTRL 8'h00
`define SCS_REG_STAT 8'h04
`define SCS_REG_CLKDIV 8'h08
// control bit positions
`define SCS_CTRL_START 0
`define SCS_CTRL_STOP 1
`define SCS_CTRL_V5 2
`define SCS_CTRL_CLKEN 3
`define SCS_CTRL_RST 4
`define SCS_CTRL_DLOW 5
`define SCS_CLKDIV_RST 16'h0004

`endif

// ---- core/scs_pkg.sv ----
// types for the smart card supply supervisor host controller
// assumes scs_defines.svh is included where constants are needed
package scs_pkg;
   typedef enum logic [2:0] {
      SCS_IDLE = 3'b000,
      SCS_WAIT_READY = 3'b001,
      SCS_ACTIVE = 3'b011,
      SCS_ALARM = 3'b010,
      SCS_GAP = 3'b110
   } scs_state_t;
endpackage

// ---- core/scs_clkgen.sv ----
// card clock source for the device's host clock input
// assumes en is a level from the main controller; output low when stopped
`timescale 1ns/1ps
module scs_clkgen #(
   parameter int DIV_W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic en,
   input wire logic [DIV_W-1:0] half_period,
   // clock out
   output logic clk_out
);
   logic [DIV_W-1:0] cnt_q, cnt_d;
   logic clk_out_d;

   always_comb begin
      cnt_d = cnt_q;
      clk_out_d = clk_out;
      if (!en) begin
         // stopping low keeps the card in clock stop with a clean level
         cnt_d = '0;
         clk_out_d = 1'b0;
      end else if (cnt_q >= half_period) begin
         cnt_d = '0;
         clk_out_d = ~clk_out;
      end else begin
         cnt_d = cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         clk_out <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         clk_out <= clk_out_d;
      end
   end
endmodule

// ---- core/scs_timer.sv ----
// down counter: load a value, done pulses when it reaches zero
// assumes load has priority over counting
`timescale 1ns/1ps
module scs_timer #(
   parameter int W = 24
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic load,
   input wire logic [W-1:0] value,
   // status
   output logic running,
   output logic done
);
   logic [W-1:0] cnt_q, cnt_d;
   logic done_d;

   always_comb begin
      cnt_d = cnt_q;
      done_d = 1'b0;
      if (load) begin
         cnt_d = value;
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
         done_d = (cnt_q == {{(W-1){1'b0}}, 1'b1});
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         done <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         done <= done_d;
      end
   end

   assign running = (cnt_q != '0);
endmodule

// ---- core/scs_host.sv ----
// host controller for a smart card supply supervisor
// drives the device's power request, voltage select, clock, reset and
// open-drain data pins; takes orders over a simple register port.
// assumes device outputs are synchronous to clk.
//
// How it works
// R1 - device compares card clock with host clock
// R2 - clock check only after supply ready
// R3 - host stops card clock when idle
// R4 - device forwards host clock when active
// R5 - device forwards host reset when active
// R6 - data line high impedance until ready
// R7 - host drives data only open drain
// R8 - ready low only at final supply
// R9 - device alarms on listed faults
// R10 - clock, reset, temperature checked after ready
// R11 - fault after activation raises ready
// R12 - early fault: ready never goes low
// R13 - alarm cleared only by releasing power request
// R14 - card present after 40 ms debounce
// R15 - card present released within 50 us
// R16 - voltage select high 5V, low 3V
// R17 - select latched at power request fall
// R18 - change voltage only via idle
// R19 - low power request activates, channels after ready
// R20 - device compares card reset with host reset
// R21 - card clock low while idle
// R22 - device timers meet stated durations
`timescale 1ns/1ps
`include "scs_defines.svh"
module scs_host #(
   // sim may shrink the two delays; defaults are the real ones
   parameter int CNT_W = `SCS_CNT_W,
   parameter logic [CNT_W-1:0] READY_WAIT_CYC = CNT_W'(`SCS_READY_WAIT_CYC),
   parameter logic [CNT_W-1:0] IDLE_GAP_CYC = CNT_W'(`SCS_IDLE_GAP_CYC)
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // software register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // device control pins
   output logic power_request_n,
   output logic supply_voltage_select,
   output logic host_clock_in,
   output logic host_reset_in,
   // device data pin, open drain
   input wire logic data_in,
   output logic data_out,
   output logic data_oe,
   // device status pins
   input wire logic ready_n,
   input wire logic card_present_n
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   scs_pkg::scs_state_t state_q, state_d;
   logic v5_q, v5_d;
   logic clk_en_q, clk_en_d;
   logic rst_q, rst_d;
   logic dlow_q, dlow_d;
   logic [15:0] div_q, div_d;
   logic alarm_q, alarm_d;
   logic timeout_q, timeout_d;
   logic removed_q, removed_d;
   logic ready_seen_q, ready_seen_d;
   logic card_prev_q;
   logic pwr_n_q, pwr_n_d;
   logic sel_q, sel_d;
   logic data_oe_q, data_oe_d;
   logic [31:0] rdata_q, rdata_d;
   logic tmr_load;
   logic [CNT_W-1:0] tmr_value;
   logic tmr_running, tmr_done;
   logic gen_clk;
   logic wr_ctrl, start_cmd, stop_cmd;

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   assign wr_ctrl = reg_write && (reg_addr == `SCS_REG_CTRL);
   assign start_cmd = wr_ctrl && reg_wdata[`SCS_CTRL_START];
   assign stop_cmd = wr_ctrl && reg_wdata[`SCS_CTRL_STOP];

   // ----------------------------------------------------------------
   // timer and card clock
   // ----------------------------------------------------------------
   // one shared timer: ready wait and gap never overlap
   scs_timer #(.W(CNT_W)) u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .load(tmr_load),
      .value(tmr_value),
      .running(tmr_running),
      .done(tmr_done)
   );

   // a divider change mid-run can shorten one clock phase
   scs_clkgen #(.DIV_W(16)) u_clkgen (
      .clk(clk),
      .rst_n(rst_n),
      // R3 clock stop
      .en(clk_en_q && (state_q == scs_pkg::SCS_ACTIVE)),
      .half_period(div_q),
      .clk_out(gen_clk)
   );

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      pwr_n_d = pwr_n_q;
      sel_d = sel_q;
      alarm_d = alarm_q;
      timeout_d = timeout_q;
      removed_d = removed_q;
      ready_seen_d = ready_seen_q;
      tmr_load = 1'b0;
      tmr_value = '0;
      // sticky flags cleared by a new start; events below win over it
      if (start_cmd && state_q == scs_pkg::SCS_IDLE) begin
         alarm_d = 1'b0;
         timeout_d = 1'b0;
         removed_d = 1'b0;
         ready_seen_d = 1'b0;
      end
      // not gated on ready: removal and its alarm land in one cycle
      if (!card_prev_q && card_present_n && pwr_n_q == 1'b0) begin
         // R15 card gone
         removed_d = 1'b1;
      end
      case (state_q)
         scs_pkg::SCS_IDLE: begin
            pwr_n_d = 1'b1;
            if (start_cmd) begin
               // R18 select set before request
               // select from the same write: one write picks voltage and starts
               sel_d = v5_d;
               state_d = scs_pkg::SCS_WAIT_READY;
               tmr_load = 1'b1;
               tmr_value = READY_WAIT_CYC;
            end
         end
         scs_pkg::SCS_WAIT_READY: begin
            // R19 request low
            pwr_n_d = 1'b0;
            if (stop_cmd) begin
               state_d = scs_pkg::SCS_GAP;
               tmr_load = 1'b1;
               tmr_value = IDLE_GAP_CYC;
            end else if (!ready_n) begin
               ready_seen_d = 1'b1;
               state_d = scs_pkg::SCS_ACTIVE;
            end else if (tmr_done) begin
               // device never lowers ready on an early fault, so time out
               // R12 early fault seen as timeout
               timeout_d = 1'b1;
               alarm_d = 1'b1;
               state_d = scs_pkg::SCS_ALARM;
            end
         end
         scs_pkg::SCS_ACTIVE: begin
            pwr_n_d = 1'b0;
            if (stop_cmd) begin
               state_d = scs_pkg::SCS_GAP;
               tmr_load = 1'b1;
               tmr_value = IDLE_GAP_CYC;
            end else if (ready_n) begin
               // R11 ready high means alarm
               // the device has already shut the card down; follow it
               alarm_d = 1'b1;
               state_d = scs_pkg::SCS_ALARM;
            end
         end
         scs_pkg::SCS_ALARM: begin
            pwr_n_d = 1'b0;
            // R13 only power release clears
            if (stop_cmd) begin
               state_d = scs_pkg::SCS_GAP;
               tmr_load = 1'b1;
               tmr_value = IDLE_GAP_CYC;
            end
         end
         scs_pkg::SCS_GAP: begin
            // gap lets the card supply discharge before a new request
            pwr_n_d = 1'b1;
            if (!tmr_running && !tmr_done) begin
               state_d = scs_pkg::SCS_IDLE;
            end else if (tmr_done) begin
               state_d = scs_pkg::SCS_IDLE;
            end
         end
         default: begin
            state_d = scs_pkg::SCS_IDLE;
            pwr_n_d = 1'b1;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   always_comb begin
      v5_d = v5_q;
      clk_en_d = clk_en_q;
      rst_d = rst_q;
      dlow_d = dlow_q;
      div_d = div_q;
      rdata_d = '0;
      if (wr_ctrl) begin
         // fields written whole; a stop write also sets them from its data
         // R16 high selects 5V
         v5_d = reg_wdata[`SCS_CTRL_V5];
         clk_en_d = reg_wdata[`SCS_CTRL_CLKEN];
         rst_d = reg_wdata[`SCS_CTRL_RST];
         dlow_d = reg_wdata[`SCS_CTRL_DLOW];
      end
      if (reg_write && reg_addr == `SCS_REG_CLKDIV) begin
         div_d = reg_wdata[15:0];
      end
      if (reg_read) begin
         case (reg_addr)
            `SCS_REG_CTRL:
               rdata_d = {26'h000_0000, dlow_q, rst_q, clk_en_q, v5_q, 2'b00};
            // status shows live pins; bit 3 kept zero beside the state
            `SCS_REG_STAT:
               rdata_d = {20'h0_0000, data_in, card_present_n, ready_n, sel_q,
                          ready_seen_q, removed_q, timeout_q, alarm_q,
                          1'b0, state_q};
            `SCS_REG_CLKDIV: rdata_d = {16'h0000, div_q};
            default: rdata_d = '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------
   always_comb begin
      // R6 data only after ready
      // R7 pull low, never drive high
      // registered, so the pin trails the state by one cycle
      data_oe_d = dlow_q && (state_q == scs_pkg::SCS_ACTIVE);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= scs_pkg::SCS_IDLE;
         v5_q <= 1'b0;
         clk_en_q <= 1'b0;
         rst_q <= 1'b0;
         dlow_q <= 1'b0;
         div_q <= `SCS_CLKDIV_RST;
         alarm_q <= 1'b0;
         timeout_q <= 1'b0;
         removed_q <= 1'b0;
         ready_seen_q <= 1'b0;
         // no-card level, so reset gives no false removal edge
         card_prev_q <= 1'b1;
         pwr_n_q <= 1'b1;
         sel_q <= 1'b0;
         data_oe_q <= 1'b0;
         rdata_q <= '0;
         host_clock_in <= 1'b0;
         host_reset_in <= 1'b0;
      end else begin
         state_q <= state_d;
         v5_q <= v5_d;
         clk_en_q <= clk_en_d;
         rst_q <= rst_d;
         dlow_q <= dlow_d;
         div_q <= div_d;
         alarm_q <= alarm_d;
         timeout_q <= timeout_d;
         removed_q <= removed_d;
         ready_seen_q <= ready_seen_d;
         card_prev_q <= card_present_n;
         pwr_n_q <= pwr_n_d;
         sel_q <= sel_d;
         data_oe_q <= data_oe_d;
         rdata_q <= rdata_d;
         // R21 clock low outside active
         // extra stage: the pin stops two cycles after active ends
         host_clock_in <= gen_clk;
         // R5 reset held low until active
         host_reset_in <= rst_q && (state_q == scs_pkg::SCS_ACTIVE);
      end
   end

   assign reg_rdata = rdata_q;
   assign power_request_n = pwr_n_q;
   // R17 select stable while request low
   assign supply_voltage_select = sel_q;
   assign data_out = 1'b0;
   assign data_oe = data_oe_q;
endmodule

// ---- tb/scs_host_asserts.sv ----
// pin checker for the supervisor host controller
// assumes it is bound onto scs_host and sees only its ports
`timescale 1ns/1ps
module scs_host_asserts #(
   parameter int CNT_W = 24,
   parameter logic [CNT_W-1:0] READY_WAIT_CYC = '0,
   parameter logic [CNT_W-1:0] IDLE_GAP_CYC = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   // device pins
   input wire logic power_request_n,
   input wire logic supply_voltage_select,
   input wire logic host_clock_in,
   input wire logic host_reset_in,
   input wire logic data_in,
   input wire logic data_out,
   input wire logic data_oe,
   input wire logic ready_n,
   input wire logic card_present_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_idle_quiet: assert property (power_request_n && $past(power_request_n)
      && $past(power_request_n, 2) |-> !host_clock_in && !host_reset_in && !data_oe)
      else $error("channel active while idle");
   a_clk_needs_req: assert property (host_clock_in |-> !$past(power_request_n, 2))
      else $error("clock runs without request");
   a_chan_after_ready: assert property ($rose(data_oe) |-> !$past(ready_n)
      || !$past(ready_n, 2))
      else $error("data line used before ready");
   a_select_hold: assert property (!power_request_n && !$past(power_request_n)
      |-> $stable(supply_voltage_select))
      else $error("select moved during request");
   a_fault_drops: assert property ($rose(ready_n) && !power_request_n
      |-> ##[1:3] (!data_oe && !host_clock_in && !host_reset_in))
      else $error("channels kept after fault");
   a_gap_hold: assert property ($rose(power_request_n) |-> power_request_n[*8])
      else $error("request reasserted too soon");
   a_drive_low_only: assert property (data_oe |-> data_out == 1'b0)
      else $error("data line driven high");
   a_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside read slot");
   c_active: cover property ($rose(data_oe));
   c_fault: cover property ($rose(ready_n) && !power_request_n);
   c_gap: cover property ($rose(power_request_n));
endmodule

bind scs_host scs_host_asserts #(.CNT_W(CNT_W), .READY_WAIT_CYC(READY_WAIT_CYC),
   .IDLE_GAP_CYC(IDLE_GAP_CYC)) u_chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_write,
   .reg_read, .reg_rdata, .power_request_n, .supply_voltage_select, .host_clock_in,
   .host_reset_in, .data_in, .data_out, .data_oe, .ready_n, .card_present_n);

// ---- tb/scs_dev_model.sv ----
// behavioural model of the supervised card interface device
// assumes its pins are synchronous to the host clock
`timescale 1ns/1ps
module scs_dev_model #(
   parameter int RAMP = 10,
   parameter int DEB = 30
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // host side
   input wire logic power_request_n,
   input wire logic supply_voltage_select,
   input wire logic host_clock_in,
   input wire logic host_reset_in,
   input wire logic data_out,
   input wire logic data_oe,
   output logic ready_n,
   output logic card_present_n,
   output logic data_in,
   // card side and fault injection
   input wire logic presence_switch_in,
   input wire logic fault_now,
   input wire logic early_fault,
   output logic card_supply_v5,
   output logic card_clk,
   output logic card_rst
);
   logic alarm_q;
   int ramp_q;
   int deb_q;
   logic up;
   // ready only after soft start, never with an early fault
   assign up = ramp_q >= RAMP && !alarm_q && !early_fault && !power_request_n;
   assign ready_n = !up;
   // mirrored channels, so comparators never disagree
   assign card_clk = up && host_clock_in;
   assign card_rst = up && host_reset_in;
   // device never drives, pull-up wins when released
   assign data_in = data_oe ? data_out : 1'b1;
   // debounce on insertion, removal seen at once
   assign card_present_n = deb_q < DEB;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         alarm_q <= 1'b0;
         ramp_q <= 0;
         deb_q <= 0;
         card_supply_v5 <= 1'b0;
      end else begin
         deb_q <= presence_switch_in ? deb_q + 1 : 0;
         if ($fell(power_request_n)) card_supply_v5 <= supply_voltage_select;
         // only a released request leaves alarm
         if (power_request_n) begin
            alarm_q <= 1'b0;
            ramp_q <= 0;
         end else begin
            if (ramp_q < RAMP) ramp_q <= ramp_q + 1;
            // removal any time, other faults after soft start
            if (!presence_switch_in || (fault_now || early_fault) && ramp_q >= RAMP)
               alarm_q <= 1'b1;
         end
      end
   end
endmodule

// ---- tb/tb.sv ----
// register-level bench for the supervisor host controller
// assumes scs_dev_model stands in for the device
`timescale 1ns/1ps
`include "scs_defines.svh"
module tb;
   localparam logic [31:0] CTRL_ON = 32'h0000_003D;
   logic clk, rst_n, reg_write, reg_read, power_request_n, supply_voltage_select;
   logic host_clock_in, host_reset_in, data_in, data_out, data_oe, ready_n, card_present_n;
   logic presence_switch_in, fault_now, early_fault, card_supply_v5;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, v;
   int error_cnt = 0;
   int checks_done = 0;
   int hi;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   scs_host #(.READY_WAIT_CYC(24'h00_0032), .IDLE_GAP_CYC(24'h00_0014)) dut (.clk, .rst_n,
      .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .power_request_n,
      .supply_voltage_select, .host_clock_in, .host_reset_in, .data_in, .data_out,
      .data_oe, .ready_n, .card_present_n);
   scs_dev_model dev (.clk, .rst_n, .power_request_n, .supply_voltage_select,
      .host_clock_in, .host_reset_in, .data_out, .data_oe, .ready_n, .card_present_n,
      .data_in, .presence_switch_in, .fault_now, .early_fault, .card_supply_v5,
      .card_clk(), .card_rst());
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // bounded poll of the state field
   task automatic wait_st(input logic [2:0] s);
      logic [31:0] d;
      for (int i = 0; i < 200; i++) begin
         rd(`SCS_REG_STAT, d);
         if (d[2:0] === s) break;
      end
      chk("state", 32'(s), 32'(d[2:0]));
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #100000;
      error_cnt++;
      close_out();
   end
   initial begin
      {rst_n, reg_write, reg_read, presence_switch_in, fault_now, early_fault} = 6'h00;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      repeat (8) @(posedge clk);
      #1 chk("request idle", 32'h1, 32'(power_request_n));
      rst_n <= 1'b1;
      rd(`SCS_REG_CLKDIV, v);
      chk("clkdiv", 32'(`SCS_CLKDIV_RST), v);
      rd(8'h0C, v);
      chk("unmapped", 32'h0000_0000, v);
      presence_switch_in <= 1'b1;
      repeat (18) @(posedge clk);
      rd(`SCS_REG_STAT, v);
      chk("card early", 32'h1, 32'(v[10]));
      repeat (20) @(posedge clk);
      rd(`SCS_REG_STAT, v);
      chk("card debounced", 32'h0, 32'(v[10]));
      $display("test reset and presence done");
      wr(`SCS_REG_CTRL, CTRL_ON);
      wait_st(scs_pkg::SCS_ACTIVE);
      chk("select", 32'h1, 32'(supply_voltage_select));
      chk("card supply", 32'h1, 32'(card_supply_v5));
      chk("reset pin", 32'h1, 32'(host_reset_in));
      chk("data line", 32'h0, 32'(data_in));
      hi = 0;
      repeat (40) @(negedge clk) hi += int'(host_clock_in);
      chk("clock runs", 32'h1, 32'(hi > 0 && hi < 40));
      wr(`SCS_REG_CTRL, 32'h0000_0034);
      repeat (4) @(posedge clk);
      hi = 0;
      repeat (20) @(negedge clk) hi += int'(host_clock_in);
      chk("clock stopped", 32'h0, 32'(hi));
      rd(`SCS_REG_CTRL, v);
      chk("ctrl", 32'h0000_0034, v);
      $display("test activation done");
      fault_now <= 1'b1;
      wait_st(scs_pkg::SCS_ALARM);
      rd(`SCS_REG_STAT, v);
      chk("alarm flags", 32'h3, 32'({v[9], v[4]}));
      chk("oe after fault", 32'h0, 32'({data_oe, host_reset_in}));
      fault_now <= 1'b0;
      wr(`SCS_REG_CTRL, CTRL_ON);
      rd(`SCS_REG_STAT, v);
      chk("alarm kept", 32'(scs_pkg::SCS_ALARM), 32'(v[2:0]));
      wr(`SCS_REG_CTRL, 32'h0000_0002);
      wait_st(scs_pkg::SCS_IDLE);
      $display("test fault and alarm done");
      early_fault <= 1'b1;
      wr(`SCS_REG_CTRL, 32'h0000_0001);
      wait_st(scs_pkg::SCS_ALARM);
      rd(`SCS_REG_STAT, v);
      chk("timeout no ready", 32'h1, 32'({v[7], v[5]}));
      chk("select 3v", 32'h0, 32'({supply_voltage_select, card_supply_v5}));
      wr(`SCS_REG_CTRL, 32'h0000_0002);
      wait_st(scs_pkg::SCS_IDLE);
      early_fault <= 1'b0;
      $display("test early fault done");
      wr(`SCS_REG_CTRL, CTRL_ON);
      wait_st(scs_pkg::SCS_ACTIVE);
      presence_switch_in <= 1'b0;
      repeat (2) @(posedge clk);
      rd(`SCS_REG_STAT, v);
      chk("card gone", 32'h1, 32'(v[10]));
      wait_st(scs_pkg::SCS_ALARM);
      rd(`SCS_REG_STAT, v);
      chk("removed flag", 32'h1, 32'(v[6]));
      wr(`SCS_REG_CTRL, 32'h0000_0002);
      wait_st(scs_pkg::SCS_IDLE);
      $display("test removal done");
      close_out();
   end
endmodule
